// ---- pkg/u9m_cfg.svh ----
// constants for the nine-bit multiprocessor serial port: offsets, fields, resets, counts
// assumes a 32-bit AXI4-Lite slave with one aligned word per register
//
// Notes on behaviour
// - nine-bit variable mode sends and receives eleven bit periods per frame
// - frame is low start, eight data bits lsb first, ninth bit, high stop
// - variable mode bit rate comes from the loaded baud rate value register
// - control bits 7 and 6 both one select the variable nine-bit mode
// - outgoing ninth bit is the last written transmit ninth bit field
// - writing a byte to the data register while the transmitter is idle loads it and starts one frame
// - frames are taken in only while the receive enable field is one
// - with reception enabled a falling receive pin starts a frame
// - in both nine-bit modes the received ninth bit lands in control bit 2
// - with filter enabled, ninth bit zero gives no receive interrupt; one gives it
// - address filtering acts only in nine-bit modes with parity disabled
// - in synchronous shift mode the filter field has no effect
// - in eight-bit mode with filter set, interrupt only on a valid high stop
// - stop bit is not stored; only eight data bits and the ninth are kept
`ifndef U9M_CFG_SVH
`define U9M_CFG_SVH
// register indices; byte address is four times the index
`define U9M_IDX_CTRL 8'h00
`define U9M_IDX_BAUD 8'h01
`define U9M_IDX_STAT 8'h02
`define U9M_IDX_CLR 8'h03
`define U9M_IDX_ENA 8'h04
`define U9M_IDX_DATA 8'hFF
// control word fields
`define U9M_CTRL_MODE_HI 7
`define U9M_CTRL_MODE_LO 6
`define U9M_CTRL_FILT 5
`define U9M_CTRL_RXEN 4
`define U9M_CTRL_TX9 3
`define U9M_CTRL_RX9 2
`define U9M_CTRL_TXP 1
`define U9M_CTRL_RXP 0
`define U9M_CTRL_PAR 8
// status bits
`define U9M_ST_RX 0
`define U9M_ST_TX 1
// reset values
`define U9M_CTRL_RST 8'h00
`define U9M_BAUD_RST 16'h0000
// bit timing: sixteen ticks per bit, sampled at the middle
`define U9M_OVS 4'hF
`define U9M_MID 4'h7
`define U9M_BITS9 4'hA
`define U9M_BITS8 4'h9
// bus responses
`define U9M_OKAY 2'h0
`define U9M_SLVERR 2'h2
`endif

// ---- pkg/u9m_pkg.sv ----
// types for the nine-bit multiprocessor serial port
// assumes u9m_cfg.svh for the numeric constants
package u9m_pkg;
  // operating modes as held in control bits 7:6
  typedef enum logic [1:0] {
    U9M_SHIFT = 2'h0,
    U9M_ASYNC8 = 2'h1,
    U9M_NINE_FIXED = 2'h2,
    U9M_NINE_VAR = 2'h3
  } u9m_mode_t;
  // software visible control fields
  typedef struct packed {
    logic par_en;
    u9m_mode_t mode;
    logic filt_en;
    logic rx_en;
    logic tx9;
  } u9m_ctrl_t;
  // one received frame
  typedef struct packed {
    logic ninth;
    logic [7:0] data;
  } u9m_rxw_t;
  typedef enum {U9M_TX_IDLE, U9M_TX_SEND} u9m_tx_st_t;
  typedef enum {U9M_RX_IDLE, U9M_RX_SHIFT} u9m_rx_st_t;
endpackage : u9m_pkg

// ---- hw/u9m_top.sv ----
// nine-bit multiprocessor serial port with AXI4-Lite register access
// assumes one system clock; RXD_I comes from a pin and is synchronised here
`include "u9m_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module u9m_top #(
  parameter int ADDR_W = 12,
  parameter int BAUD_W = 16
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic RXD_I,
  output logic TXD_O,
  output logic IRQ_O
);
  // the data register index 0xFF needs ten byte-address bits
  if (ADDR_W < 10 || BAUD_W < 1 || BAUD_W > 24) begin : g_chk
    $error("u9m_top: unsupported ADDR_W or BAUD_W");
  end

  u9m_pkg::u9m_ctrl_t ctrl_q;
  logic [BAUD_W-1:0] baud_q;
  logic [1:0] stat_q;
  logic [1:0] ena_q;
  u9m_pkg::u9m_rxw_t rxbuf_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic wr_go;
  logic [7:0] wr_idx, rd_idx;
  logic wr_ctrl, wr_baud, wr_clr, wr_ena, wr_data, wr_hit;
  logic nine, tx_done, rx_done, rx_irq_ok;

  // the write fires once both address and data are held and no answer is pending
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign wr_idx = awaddr_q[9:2];
  assign rd_idx = S_AXI_ARADDR_I[9:2];
  assign nine = ctrl_q.mode[1];

  // write decode; bits above the data register's index must be zero
  always_comb begin
    wr_ctrl = 1'b0;
    wr_baud = 1'b0;
    wr_clr = 1'b0;
    wr_ena = 1'b0;
    wr_data = 1'b0;
    if (awaddr_q[1:0] != 2'h0 || (ADDR_W > 10 && |(awaddr_q >> 10))) begin
      wr_hit = 1'b0;
    end else if (wr_idx == `U9M_IDX_CTRL) begin
      wr_ctrl = wr_go;
      wr_hit = 1'b1;
    end else if (wr_idx == `U9M_IDX_BAUD) begin
      wr_baud = wr_go;
      wr_hit = 1'b1;
    end else if (wr_idx == `U9M_IDX_STAT) begin
      wr_hit = 1'b1;
    end else if (wr_idx == `U9M_IDX_CLR) begin
      wr_clr = wr_go;
      wr_hit = 1'b1;
    end else if (wr_idx == `U9M_IDX_ENA) begin
      wr_ena = wr_go;
      wr_hit = 1'b1;
    end else if (wr_idx == `U9M_IDX_DATA) begin
      wr_data = wr_go && wstrb_q[0];
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // write address and data channels, taken in either order
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `U9M_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      if (awready_q && S_AXI_AWVALID_I) begin
        awready_q <= 1'b0;
        awaddr_q <= S_AXI_AWADDR_I;
      end
      if (wready_q && S_AXI_WVALID_I) begin
        wready_q <= 1'b0;
        wdata_q <= S_AXI_WDATA_I;
        wstrb_q <= S_AXI_WSTRB_I;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `U9M_OKAY : `U9M_SLVERR;
      end else if (bvalid_q && S_AXI_BREADY_I) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= `U9M_OKAY;
    end else if (arready_q && S_AXI_ARVALID_I) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rresp_q <= `U9M_OKAY;
      rdata_q <= 32'h0;
      if (S_AXI_ARADDR_I[1:0] != 2'h0 || (ADDR_W > 10 && |(S_AXI_ARADDR_I >> 10))) begin
        rresp_q <= `U9M_SLVERR;
      end else if (rd_idx == `U9M_IDX_CTRL) begin
        rdata_q[`U9M_CTRL_PAR] <= ctrl_q.par_en;
        rdata_q[`U9M_CTRL_MODE_HI:`U9M_CTRL_MODE_LO] <= ctrl_q.mode;
        rdata_q[`U9M_CTRL_FILT] <= ctrl_q.filt_en;
        rdata_q[`U9M_CTRL_RXEN] <= ctrl_q.rx_en;
        rdata_q[`U9M_CTRL_TX9] <= ctrl_q.tx9;
        rdata_q[`U9M_CTRL_RX9] <= rxbuf_q.ninth;
        rdata_q[`U9M_CTRL_TXP] <= stat_q[`U9M_ST_TX];
        rdata_q[`U9M_CTRL_RXP] <= stat_q[`U9M_ST_RX];
      end else if (rd_idx == `U9M_IDX_BAUD) begin
        rdata_q[BAUD_W-1:0] <= baud_q;
      end else if (rd_idx == `U9M_IDX_STAT) begin
        rdata_q[1:0] <= stat_q;
      end else if (rd_idx == `U9M_IDX_CLR) begin
        rdata_q[1:0] <= 2'h0; // write-only
      end else if (rd_idx == `U9M_IDX_ENA) begin
        rdata_q[1:0] <= ena_q;
      end else if (rd_idx == `U9M_IDX_DATA) begin
        rdata_q[7:0] <= rxbuf_q.data;
      end else begin
        rresp_q <= `U9M_SLVERR;
      end
    end else if (rvalid_q && S_AXI_RREADY_I) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // control and baud registers; the filter field comes up clear, firmware sets it
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= '0;
      baud_q <= '0;
      ena_q <= 2'h0;
    end else begin
      if (wr_ctrl && wstrb_q[0]) begin
        ctrl_q.mode <= u9m_pkg::u9m_mode_t'(wdata_q[`U9M_CTRL_MODE_HI:`U9M_CTRL_MODE_LO]);
        ctrl_q.filt_en <= wdata_q[`U9M_CTRL_FILT];
        ctrl_q.rx_en <= wdata_q[`U9M_CTRL_RXEN];
        ctrl_q.tx9 <= wdata_q[`U9M_CTRL_TX9];
      end
      if (wr_ctrl && wstrb_q[1]) begin
        ctrl_q.par_en <= wdata_q[`U9M_CTRL_PAR];
      end
      if (wr_baud) begin
        baud_q <= wdata_q[BAUD_W-1:0];
      end
      if (wr_ena && wstrb_q[0]) begin
        ena_q <= wdata_q[1:0];
      end
    end
  end

  // sticky pending bits; a new event beats a clear in the same cycle
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      stat_q <= 2'h0;
    end else begin
      if (wr_clr && wstrb_q[0]) begin
        stat_q <= stat_q & ~wdata_q[1:0];
      end
      if (rx_done && rx_irq_ok) begin
        stat_q[`U9M_ST_RX] <= 1'b1;
      end
      if (tx_done) begin
        stat_q[`U9M_ST_TX] <= 1'b1;
      end
    end
  end

  // interrupt level; one cycle behind the status so it leaves a flop
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(stat_q & ena_q);
    end
  end

  // oversampling tick: fixed nine-bit mode runs one tick per clock,
  // the other modes divide by baud value plus one
  logic [BAUD_W-1:0] div_q;
  logic tick;
  assign tick = (ctrl_q.mode == u9m_pkg::U9M_NINE_FIXED) || (div_q == '0);
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      div_q <= '0;
    end else if (div_q == '0) begin
      div_q <= baud_q;
    end else begin
      div_q <= div_q - 1'b1;
    end
  end

  // transmitter; a data write while a frame is going out is dropped
  u9m_pkg::u9m_tx_st_t tx_st_q;
  logic [10:0] tx_sh_q;
  logic [3:0] tx_ph_q, tx_bit_q;
  logic [3:0] nbits;
  assign nbits = nine ? `U9M_BITS9 : `U9M_BITS8;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tx_st_q <= u9m_pkg::U9M_TX_IDLE;
      tx_sh_q <= 11'h7FF;
      tx_ph_q <= 4'h0;
      tx_bit_q <= 4'h0;
      TXD_O <= 1'b1;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      case (tx_st_q)
        u9m_pkg::U9M_TX_IDLE: begin
          TXD_O <= 1'b1;
          if (wr_data) begin
            // stop, ninth, data lsb first, start; eight-bit frames put the stop in bit 9
            tx_sh_q <= {1'b1, nine ? ctrl_q.tx9 : 1'b1, wdata_q[7:0], 1'b0};
            tx_ph_q <= 4'h0;
            tx_bit_q <= 4'h0;
            tx_st_q <= u9m_pkg::U9M_TX_SEND;
          end
        end
        u9m_pkg::U9M_TX_SEND: begin
          TXD_O <= tx_sh_q[0];
          if (tick) begin
            tx_ph_q <= tx_ph_q + 4'h1;
            if (tx_ph_q == `U9M_OVS) begin
              tx_sh_q <= {1'b1, tx_sh_q[10:1]};
              tx_bit_q <= tx_bit_q + 4'h1;
              if (tx_bit_q == nbits) begin
                tx_st_q <= u9m_pkg::U9M_TX_IDLE;
                tx_done <= 1'b1;
              end
            end
          end
        end
        default: tx_st_q <= u9m_pkg::U9M_TX_IDLE;
      endcase
    end
  end

  // receive pin synchroniser and a third stage for edge detection
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= RXD_I;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end

  // receiver: sample each bit at its middle tick
  u9m_pkg::u9m_rx_st_t rx_st_q;
  logic [3:0] rx_ph_q, rx_bit_q;
  logic [8:0] rx_sh_q;
  logic rx_stop_q, rx_ninth;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rx_st_q <= u9m_pkg::U9M_RX_IDLE;
      rx_ph_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_stop_q <= 1'b0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_st_q)
        u9m_pkg::U9M_RX_IDLE: begin
          if (ctrl_q.rx_en && rx_s3_q && !rx_s2_q) begin
            rx_ph_q <= 4'h0;
            rx_bit_q <= 4'h0;
            rx_st_q <= u9m_pkg::U9M_RX_SHIFT;
          end
        end
        u9m_pkg::U9M_RX_SHIFT: begin
          if (!ctrl_q.rx_en) begin
            rx_st_q <= u9m_pkg::U9M_RX_IDLE;
          end else if (tick) begin
            rx_ph_q <= rx_ph_q + 4'h1;
            if (rx_ph_q == `U9M_MID) begin
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q == 4'h0 && rx_s2_q) begin
                rx_st_q <= u9m_pkg::U9M_RX_IDLE; // false start glitch
              end else if (rx_bit_q == nbits) begin
                rx_stop_q <= rx_s2_q; // checked, never stored as data
                rx_done <= 1'b1;
                rx_st_q <= u9m_pkg::U9M_RX_IDLE;
              end else if (rx_bit_q != 4'h0) begin
                rx_sh_q <= {rx_s2_q, rx_sh_q[8:1]}; // lsb first
              end
            end
          end
        end
        default: rx_st_q <= u9m_pkg::U9M_RX_IDLE;
      endcase
    end
  end

  // in eight-bit frames the last shifted bit is d7, so the word sits one higher
  assign rx_ninth = rx_sh_q[8];

  // receive interrupt qualification by mode and filter
  always_comb begin
    rx_irq_ok = 1'b1;
    if (ctrl_q.mode == u9m_pkg::U9M_SHIFT) begin
      rx_irq_ok = 1'b1;
    end else if (ctrl_q.mode == u9m_pkg::U9M_ASYNC8) begin
      rx_irq_ok = !ctrl_q.filt_en || rx_stop_q;
    end else if (ctrl_q.filt_en && !ctrl_q.par_en) begin
      rx_irq_ok = rx_ninth;
    end
  end

  // received word store; the filter only gates the interrupt, data still lands
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rxbuf_q <= '0;
    end else if (rx_done) begin
      if (nine) begin
        rxbuf_q.data <= rx_sh_q[7:0];
        rxbuf_q.ninth <= rx_ninth;
      end else begin
        rxbuf_q.data <= rx_sh_q[8:1];
      end
    end
  end

  // bus outputs straight from flops
  assign S_AXI_AWREADY_O = awready_q;
  assign S_AXI_WREADY_O = wready_q;
  assign S_AXI_BVALID_O = bvalid_q;
  assign S_AXI_BRESP_O = bresp_q;
  assign S_AXI_ARREADY_O = arready_q;
  assign S_AXI_RVALID_O = rvalid_q;
  assign S_AXI_RDATA_O = rdata_q;
  assign S_AXI_RRESP_O = rresp_q;
endmodule : u9m_top
`default_nettype wire

// ---- test/u9m_chk.sv ----
// assertions on the bus and the transmit pin of the nine-bit serial port
// assumes binding into u9m_top and a baud value of 1 (32 clocks a bit)
`include "u9m_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module u9m_chk #(
  parameter int ADDR_W = 12
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic [1:0] S_AXI_RRESP_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic TXD_O
);
  localparam int low_max = 320; // start plus nine zero bits
  logic aw_bad_q;
  logic ar_bad_q;
  int low_q;
  function automatic logic bad(input logic [ADDR_W-1:0] a);
    return !(a inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h3FC});
  endfunction : bad
  // remember whether each taken address was mapped; the answer is judged on it
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      aw_bad_q <= 1'b0;
      ar_bad_q <= 1'b0;
    end else begin
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) aw_bad_q <= bad(S_AXI_AWADDR_I);
      if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) ar_bad_q <= bad(S_AXI_ARADDR_I);
    end
  end
  // length of the current low run on the line; a lost stop bit makes it grow
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) low_q <= 0;
    else low_q <= TXD_O ? 0 : low_q + 1;
  end
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // the register is written one edge after the take, and the answer stands from then on
  AST_WR_ANSWER: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O |=> ##1 S_AXI_BVALID_O) else $error("write not answered");
  AST_RD_ANSWER: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O)
    else $error("read not answered");
  AST_B_BUSY: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
    else $error("write ready during response");
  AST_R_BUSY: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
    else $error("read ready during response");
  AST_R_STANDS: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O
    && $stable(S_AXI_RDATA_O) && $stable(S_AXI_RRESP_O)) else $error("read answer moved");
  AST_WR_RESP: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O ==
    (aw_bad_q ? `U9M_SLVERR : `U9M_OKAY)) else $error("write response wrong");
  AST_RD_ERR: assert property (S_AXI_RVALID_O && ar_bad_q |-> S_AXI_RRESP_O == `U9M_SLVERR)
    else $error("unmapped read not refused");
  AST_TX_LOW: assert property (low_q <= low_max)
    else $error("line low past a frame");
  AST_TX_START: assert property (S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I
    && S_AXI_WREADY_O && S_AXI_AWADDR_I == 12'h3FC |-> ##[1:8] !TXD_O)
    else $error("data write sent no start bit");
  C_WR: cover property (S_AXI_BVALID_O && S_AXI_BREADY_I);
  C_RD: cover property (S_AXI_RVALID_O && S_AXI_RREADY_I);
  C_TX: cover property ($fell(TXD_O));
endmodule : u9m_chk
bind u9m_top u9m_chk #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ---- test/u9m_node.sv ----
// far-end node on the shared serial line: sends frames and decodes what it hears
// assumes the bench keeps bit_clks at sixteen tick periods of the port
`timescale 1ns/10ps
`default_nettype none
module u9m_node (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  int bit_clks = 32;
  int heard_n = 0;
  logic [8:0] heard;
  initial rxd_o = 1'b1; // an idle line sits high
  // start bit, then w[0..n] lsb first; the last of them is the stop bit
  task automatic send(input logic [9:0] w, input int n);
    rxd_o <= 1'b0;
    repeat (bit_clks) @(posedge clk_i);
    for (int i = 0; i <= n; i++) begin
      rxd_o <= w[i];
      repeat (bit_clks) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
  endtask : send
  // mid-bit sampling keeps a shortened start bit harmless
  always begin
    @(negedge txd_i);
    repeat (bit_clks / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_clks) @(posedge clk_i);
      heard[i] = txd_i;
    end
    repeat (bit_clks) @(posedge clk_i);
    heard_n += int'(txd_i); // only frames with a high stop count
  end
endmodule : u9m_node
`default_nettype wire

// ---- test/u9m_tb_top.sv ----
// bench for the nine-bit serial port: bus master tasks, far-end node, scenarios
// assumes u9m_top, u9m_node and the bound checker are compiled before it
`include "u9m_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module u9m_tb_top;
  localparam logic [11:0] a_ctrl = {2'h0, `U9M_IDX_CTRL, 2'h0};
  localparam logic [11:0] a_baud = {2'h0, `U9M_IDX_BAUD, 2'h0};
  localparam logic [11:0] a_stat = {2'h0, `U9M_IDX_STAT, 2'h0};
  localparam logic [11:0] a_clr = {2'h0, `U9M_IDX_CLR, 2'h0};
  localparam logic [11:0] a_ena = {2'h0, `U9M_IDX_ENA, 2'h0};
  localparam logic [11:0] a_data = {2'h0, `U9M_IDX_DATA, 2'h0};
  logic clk, rst_n, awv, wv, bready, arv, rready, awr, wr_r, bv, arr, rv, txd, rxd, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic irq_on = 1'b1;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  u9m_top dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wr_r),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rready), .RXD_I(rxd), .TXD_O(txd), .IRQ_O(irq));
  u9m_node node (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
  // 200 MHz system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard: far above the few thousand cycles the frames need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic summarize;
    if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check
  // both write channels offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
    end while (!bv);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask : wr
  // ready is raised late on purpose so the answer has to stand a cycle
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
      if (rv) rready <= 1'b1;
    end while (!(rv && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask : rd
  task automatic wo(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    check("wresp", {30'h0, `U9M_OKAY}, {30'h0, r});
  endtask : wo
  task automatic ro(input string n, input logic [11:0] a, input logic [31:0] e,
                    input logic [31:0] m = 32'hFFFFFFFF);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check(n, e, d & m);
  endtask : ro
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 800) begin
      @(posedge clk);
      n++;
    end
    check("irq", 32'h1, {31'h0, irq});
  endtask : wait_irq
  // one frame from the far end, then the event bit and the interrupt line
  task automatic rx_case(input logic [31:0] c, input logic [9:0] w, input int n, input logic ev);
    wo(a_ctrl, c);
    node.send(w, n);
    repeat (8) @(posedge clk);
    check("rx irq", {31'h0, ev & irq_on}, {31'h0, irq});
    ro("rx stat", a_stat, {31'h0, ev});
    wo(a_clr, 32'h1);
  endtask : rx_case
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    ro("ctrl", a_ctrl, 32'h0);
    ro("baud", a_baud, 32'h0);
    wo(a_baud, 32'h1);
    ro("baud", a_baud, 32'h1);
    wr(12'h014, 32'h0, r);
    check("wr unmapped", {30'h0, `U9M_SLVERR}, {30'h0, r});
    rd(12'h002, d, r);
    check("rd unaligned", {30'h0, `U9M_SLVERR}, {30'h0, r});
  endtask : t_regs
  task automatic t_tx;
    wo(a_ena, 32'h2);
    for (int k = 0; k < 2; k++) begin
      wo(a_ctrl, k ? 32'hC0 : 32'hC8);
      wo(a_data, k ? 32'h3C : 32'hA5);
      wait_irq();
      check("heard", k ? 32'h03C : 32'h1A5, {23'h0, node.heard});
      check("stops", k + 1, node.heard_n);
      ro("tx stat", a_stat, 32'h2);
      wo(a_clr, 32'h2);
      check("irq clr", 32'h0, {31'h0, irq});
    end
  endtask : t_tx
  task automatic t_filter;
    wo(a_ena, 32'h1);
    rx_case(32'hF0, {2'b10, 8'h55}, 9, 1'b0);
    ro("data", a_data, 32'h55);
    rx_case(32'hF0, {2'b11, 8'h12}, 9, 1'b1);
    ro("rx9", a_ctrl, 32'h4, 32'h4);
    ro("data", a_data, 32'h12);
    rx_case(32'hD0, {2'b10, 8'h77}, 9, 1'b1);
    ro("rx9", a_ctrl, 32'h0, 32'h4);
    rx_case(32'h1F0, {2'b10, 8'h66}, 9, 1'b1);
    node.bit_clks = 16;
    rx_case(32'hB0, {2'b10, 8'h66}, 9, 1'b0);
    rx_case(32'hB0, {2'b11, 8'h99}, 9, 1'b1);
    ro("rx9", a_ctrl, 32'h4, 32'h4);
    node.bit_clks = 32;
  endtask : t_filter
  task automatic t_modes;
    rx_case(32'hE0, {2'b11, 8'h5A}, 9, 1'b0);
    rx_case(32'h70, {2'b00, 8'h5A}, 8, 1'b0);
    rx_case(32'h70, {2'b01, 8'h5A}, 8, 1'b1);
    // a bad stop with the filter set must still interrupt in shift mode
    rx_case(32'h30, {2'b00, 8'hC3}, 8, 1'b1);
    irq_on = 1'b0;
    wo(a_ena, 32'h0);
    rx_case(32'h30, {2'b01, 8'hA5}, 8, 1'b1);
  endtask : t_modes
  // reset, then the scenarios in order
  initial begin
    rst_n = 1'b0;
    {awv, wv, bready, arv, rready} = 5'h00;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_tx();
    t_filter();
    t_modes();
    summarize();
  end
endmodule : u9m_tb_top
`default_nettype wire
